//--- src/wta_pkg.sv
// Purpose: Shared constants and carriers for the watch time, alarm and stopwatch block.
// Assumes: The block sits in an always-on domain clocked by mclk.
// Notes: Event vector bit positions are fixed here and used by the pins.
// How it works
// - Crystal edges prescaled to one-second tick
// - Seconds, minutes, hours, days counters kept
// - Periodic second, minute, hour, day events
// - Enabled alarm flags when time ticks onto setting
// - Time-of-day alarm and day-plus-time alarm
// - Stopwatch loaded, decrements every second tick
// - Enabled stopwatch flags underflow past zero
// - Pending enabled events wake processor from sleep
// - Same events wake deep sleep, regulator
// - Counting continues while system clocks stop
// - State held through hibernate, own reset only
package wta_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CRYSTAL_FREQ_HZ = 32768;
  localparam int unsigned TICK_FREQ_HZ = 1;
  localparam int unsigned PRESCALE_COUNT = CRYSTAL_FREQ_HZ / TICK_FREQ_HZ;

  // ==========================================================
  // Counter moduli and field widths
  localparam int unsigned SEC_MOD = 60;
  localparam int unsigned MIN_MOD = 60;
  localparam int unsigned HOUR_MOD = 24;
  localparam int unsigned DAY_MOD = 32768;
  localparam int unsigned SEC_W = 6;
  localparam int unsigned MIN_W = 6;
  localparam int unsigned HOUR_W = 5;
  localparam int unsigned DAY_W = 15;
  localparam int unsigned STOPWATCH_W = 16;

  // ==========================================================
  // Event vector positions
  localparam int unsigned EV_SEC = 0;
  localparam int unsigned EV_MIN = 1;
  localparam int unsigned EV_HOUR = 2;
  localparam int unsigned EV_DAY = 3;
  localparam int unsigned EV_ALARM_TOD = 4;
  localparam int unsigned EV_ALARM_DAY = 5;
  localparam int unsigned EV_STOPWATCH = 6;
  localparam int unsigned NUM_EV = 7;

  typedef struct packed {
    logic [DAY_W-1:0] day;
    logic [HOUR_W-1:0] hour;
    logic [MIN_W-1:0] min;
    logic [SEC_W-1:0] sec;
  } wta_time_s;

  // ==========================================================
  // Reset values
  localparam wta_time_s RESET_TIME = '0;
  localparam logic [NUM_EV-1:0] RESET_PENDING = '0;

endpackage

//--- src/wta_top.sv
// Purpose: Watch time keeping with periodic events, two alarms and a stopwatch.
// Assumes: All inputs synchronous to mclk; the crystal input is sampled as a level.
// Notes: Control and status are plain pins; there is no register bus.
`timescale 1ns/1ps

// ==========================================================
// Modulo counter with carry out
module wta_wrap_cnt #(
  parameter int unsigned MOD = 60,
  parameter int unsigned W = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic inc,
  input wire logic load,
  input wire logic [W-1:0] load_value,
  // Status
  output logic [W-1:0] cnt,
  output logic carry
);
  logic [W-1:0] next_cnt;
  logic at_top;

  always_comb begin
    at_top = (cnt == W'(MOD - 1));
    carry = inc && at_top && !load;
    next_cnt = cnt;
    if (load) begin
      next_cnt = load_value;
    end else if (inc) begin
      next_cnt = at_top ? '0 : cnt + W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule

// ==========================================================
// Top level
module wta_top #(
  parameter int unsigned PRESCALE_DIV = wta_pkg::PRESCALE_COUNT,
  parameter int unsigned SW_W = wta_pkg::STOPWATCH_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Crystal pins
  input wire logic crystal_clock_input,
  output logic crystal_drive_output,
  // Current time
  input wire logic time_load,
  input wire wta_pkg::wta_time_s time_load_value,
  output wta_pkg::wta_time_s cur_time,
  // Alarms
  input wire logic alarm_tod_en,
  input wire wta_pkg::wta_time_s alarm_tod_value,
  input wire logic alarm_day_en,
  input wire wta_pkg::wta_time_s alarm_day_value,
  // Stopwatch
  input wire logic sw_en,
  input wire logic sw_load,
  input wire logic [SW_W-1:0] sw_load_value,
  output logic [SW_W-1:0] sw_count,
  // Events
  input wire logic [wta_pkg::NUM_EV-1:0] event_en,
  input wire logic [wta_pkg::NUM_EV-1:0] event_clear,
  output logic [wta_pkg::NUM_EV-1:0] event_pending,
  // Interrupt and wake-up
  input wire logic regulator_wake_en,
  output logic irq,
  output logic sleep_wake,
  output logic regulator_wake
);
  import wta_pkg::*;

  localparam int unsigned PS_W = $clog2(PRESCALE_DIV) + 1;

  // ==========================================================
  // Prescaler
  logic xtal_q;
  logic next_xtal_q;
  logic next_drive;
  logic [PS_W-1:0] ps_cnt;
  logic [PS_W-1:0] next_ps_cnt;
  logic tick;
  logic xtal_rise;

  always_comb begin
    next_xtal_q = crystal_clock_input;
    // Inverting drive closes the oscillator loop around the crystal
    next_drive = !crystal_clock_input;
    xtal_rise = crystal_clock_input && !xtal_q;
    tick = 1'b0;
    next_ps_cnt = ps_cnt;
    if (time_load) begin
      // Restart the second so the loaded time gets a full first second
      next_ps_cnt = '0;
    end else if (xtal_rise) begin
      if (ps_cnt == PS_W'(PRESCALE_DIV - 1)) begin
        next_ps_cnt = '0;
        tick = 1'b1;
      end else begin
        next_ps_cnt = ps_cnt + PS_W'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      xtal_q <= 1'b0;
      crystal_drive_output <= 1'b0;
      ps_cnt <= '0;
    end else begin
      xtal_q <= next_xtal_q;
      crystal_drive_output <= next_drive;
      ps_cnt <= next_ps_cnt;
    end
  end

  // ==========================================================
  // Time counters
  logic sec_carry;
  logic min_carry;
  logic hour_carry;
  logic day_carry;

  wta_wrap_cnt #(.MOD(SEC_MOD), .W(SEC_W)) u_sec (
    .clk(mclk),
    .rst_b(rst_b),
    .inc(tick),
    .load(time_load),
    .load_value(time_load_value.sec),
    .cnt(cur_time.sec),
    .carry(sec_carry)
  );

  wta_wrap_cnt #(.MOD(MIN_MOD), .W(MIN_W)) u_min (
    .clk(mclk),
    .rst_b(rst_b),
    .inc(sec_carry),
    .load(time_load),
    .load_value(time_load_value.min),
    .cnt(cur_time.min),
    .carry(min_carry)
  );

  wta_wrap_cnt #(.MOD(HOUR_MOD), .W(HOUR_W)) u_hour (
    .clk(mclk),
    .rst_b(rst_b),
    .inc(min_carry),
    .load(time_load),
    .load_value(time_load_value.hour),
    .cnt(cur_time.hour),
    .carry(hour_carry)
  );

  wta_wrap_cnt #(.MOD(DAY_MOD), .W(DAY_W)) u_day (
    .clk(mclk),
    .rst_b(rst_b),
    .inc(hour_carry),
    .load(time_load),
    .load_value(time_load_value.day),
    .cnt(cur_time.day),
    .carry(day_carry)
  );

  // ==========================================================
  // Stopwatch
  logic [SW_W-1:0] next_sw_count;
  logic sw_under;

  always_comb begin
    next_sw_count = sw_count;
    sw_under = 1'b0;
    if (sw_load) begin
      next_sw_count = sw_load_value;
    end else if (sw_en && tick) begin
      next_sw_count = sw_count - SW_W'(1);
      sw_under = (sw_count == '0);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sw_count <= '0;
    end else begin
      sw_count <= next_sw_count;
    end
  end

  // ==========================================================
  // Alarm compare, one cycle after the time has moved
  logic moved;
  logic next_moved;
  logic hit_tod;
  logic hit_day;

  always_comb begin
    // Day carry is folded in so a full wrap of the day counter still counts as movement
    next_moved = tick || day_carry;
    hit_tod = (cur_time.hour == alarm_tod_value.hour) && (cur_time.min == alarm_tod_value.min)
      && (cur_time.sec == alarm_tod_value.sec);
    hit_day = hit_tod && (cur_time.day == alarm_day_value.day)
      && (cur_time.hour == alarm_day_value.hour) && (cur_time.min == alarm_day_value.min)
      && (cur_time.sec == alarm_day_value.sec);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      moved <= 1'b0;
    end else begin
      moved <= next_moved;
    end
  end

  // ==========================================================
  // Pending flags and wake-up
  logic [NUM_EV-1:0] ev_set;
  logic [NUM_EV-1:0] next_pending;
  logic next_irq;
  logic next_regulator_wake;
  logic hit_tod_day_agree;

  always_comb begin
    ev_set = '0;
    ev_set[EV_SEC] = tick;
    ev_set[EV_MIN] = sec_carry;
    ev_set[EV_HOUR] = min_carry;
    ev_set[EV_DAY] = hour_carry;
    hit_tod_day_agree = (alarm_day_value.hour == alarm_tod_value.hour)
      && (alarm_day_value.min == alarm_tod_value.min)
      && (alarm_day_value.sec == alarm_tod_value.sec);
    ev_set[EV_ALARM_TOD] = alarm_tod_en && moved && hit_tod;
    ev_set[EV_ALARM_DAY] = alarm_day_en && moved && (hit_day
      || ((cur_time.day == alarm_day_value.day) && !hit_tod_day_agree
      && (cur_time.hour == alarm_day_value.hour) && (cur_time.min == alarm_day_value.min)
      && (cur_time.sec == alarm_day_value.sec)));
    ev_set[EV_STOPWATCH] = sw_under;
    next_pending = (event_pending & ~event_clear) | ev_set;
    next_irq = |(next_pending & event_en);
    next_regulator_wake = next_irq && regulator_wake_en;
  end

  // only the always-on reset clears state
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      event_pending <= RESET_PENDING;
      irq <= 1'b0;
      sleep_wake <= 1'b0;
      regulator_wake <= 1'b0;
    end else begin
      event_pending <= next_pending;
      irq <= next_irq;
      sleep_wake <= next_irq;
      regulator_wake <= next_regulator_wake;
    end
  end

endmodule

//--- bench/wta_properties.sv
// Purpose: Pin-level checks on the watch block.
// Assumes: One mclk domain, rst_b async active low.
// Notes: Bound from the bench top file.
`timescale 1ns/1ps
module wta_properties #(
  parameter int unsigned SW_W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Inputs seen
  input wire logic time_load,
  input wire wta_pkg::wta_time_s time_load_value,
  input wire logic sw_load,
  input wire logic [SW_W-1:0] sw_load_value,
  input wire logic [wta_pkg::NUM_EV-1:0] event_en,
  input wire logic [wta_pkg::NUM_EV-1:0] event_clear,
  input wire logic regulator_wake_en,
  // Outputs seen
  input wire wta_pkg::wta_time_s cur_time,
  input wire logic [SW_W-1:0] sw_count,
  input wire logic [wta_pkg::NUM_EV-1:0] event_pending,
  input wire logic irq,
  input wire logic sleep_wake,
  input wire logic regulator_wake
);
  import wta_pkg::*;
  // ==========
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  property p_irq; irq == |(event_pending & $past(event_en)) && sleep_wake == irq; endproperty
  a_irq: assert property (p_irq) else $error("irq wrong");
  property p_reg_wake; regulator_wake == (irq && $past(regulator_wake_en)); endproperty
  a_reg_wake: assert property (p_reg_wake) else $error("regulator wake wrong");
  property p_sticky; ($past(event_pending) & ~event_pending & ~$past(event_clear)) == 7'h00;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag fell uncleared");
  property p_sec_step; $changed(cur_time.sec) && !$past(time_load) |->
    cur_time.sec == ($past(cur_time.sec) == 6'h3b ? 6'h00 : $past(cur_time.sec) + 6'h01);
  endproperty
  a_sec_step: assert property (p_sec_step) else $error("second step wrong");
  property p_sec_flag; $changed(cur_time.sec) && !$past(time_load) |-> event_pending[EV_SEC];
  endproperty
  a_sec_flag: assert property (p_sec_flag) else $error("second flag missing");
  property p_min_carry; $changed(cur_time.min) && !$past(time_load) |->
    cur_time.sec == 6'h00 && event_pending[EV_MIN]; endproperty
  a_min_carry: assert property (p_min_carry) else $error("minute carry wrong");
  property p_load; time_load |=> cur_time == $past(time_load_value); endproperty
  a_load: assert property (p_load) else $error("time load wrong");
  property p_sw_load; sw_load |=> sw_count == $past(sw_load_value); endproperty
  a_sw_load: assert property (p_sw_load) else $error("stopwatch load wrong");
  property p_sw_step; $changed(sw_count) && !$past(sw_load) |-> sw_count + 1'b1 ==
    $past(sw_count) && ($past(sw_count) != 16'h0 || event_pending[EV_STOPWATCH]); endproperty
  a_sw_step: assert property (p_sw_step) else $error("stopwatch step wrong");
endmodule

//--- bench/wta_tb_top.sv
// Purpose: Directed regression of the watch block.
// Assumes: PRESCALE_DIV cut to 4, so one second is 8 mclk cycles.
// Notes: Crystal toggled by hand, one cycle high and one low.
`timescale 1ns/1ps
module watch_time_alarm_stopwatch_tb_top;
  import wta_pkg::*;
  localparam int unsigned DIV = 4;
  logic mclk, rst_b, crystal_clock_input, crystal_drive_output, time_load, sw_en;
  logic alarm_tod_en, alarm_day_en, sw_load, regulator_wake_en, irq, sleep_wake;
  logic regulator_wake;
  wta_time_s time_load_value, cur_time, alarm_tod_value, alarm_day_value;
  logic [15:0] sw_load_value, sw_count;
  logic [NUM_EV-1:0] event_en, event_clear, event_pending;
  int fails = 0;
  int cmp_count = 0;
  wta_top #(.PRESCALE_DIV(DIV), .SW_W(16)) i_dut (.mclk, .rst_b, .crystal_clock_input,
    .crystal_drive_output, .time_load, .time_load_value, .cur_time, .alarm_tod_en,
    .alarm_tod_value, .alarm_day_en, .alarm_day_value, .sw_en, .sw_load, .sw_load_value,
    .sw_count, .event_en, .event_clear, .event_pending, .regulator_wake_en, .irq,
    .sleep_wake, .regulator_wake);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // ==========
  // Helpers
  task cyc;
    @(posedge mclk);
    #1;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task rises(input int n);
    repeat (n) begin
      crystal_clock_input = 1'b1;
      cyc;
      crystal_clock_input = 1'b0;
      cyc;
    end
  endtask
  task clr;
    event_clear = 7'h7f;
    cyc;
    event_clear = 7'h00;
  endtask
  task ld(input wta_time_s v);
    time_load_value = v;
    time_load = 1'b1;
    cyc;
    time_load = 1'b0;
    clr;
  endtask
  task wrap_up;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========
  // Scenarios
  task t_tick;
    ld(32'h0);
    rises(DIV - 1);
    chk("sec early", 32'h0, cur_time);
    chk("drive idle", 32'h1, crystal_drive_output);
    // Last crystal rise by hand so the inverted drive is seen in both levels
    crystal_clock_input = 1'b1;
    cyc;
    chk("drive on rise", 32'h0, crystal_drive_output);
    crystal_clock_input = 1'b0;
    cyc;
    chk("sec", 32'h1, cur_time);
    chk("pending", 32'h01, event_pending);
    $display("test tick done");
  endtask
  task t_carry;
    ld({15'h7fff, 5'h17, 6'h3b, 6'h3b});
    rises(DIV);
    chk("wrap", 32'h0, cur_time);
    chk("periodic", 32'h0f, event_pending);
    ld({15'h0005, 5'h03, 6'h3a, 6'h3b});
    rises(DIV);
    chk("min", {15'h0005, 5'h03, 6'h3b, 6'h00}, cur_time);
    chk("min flag", 32'h03, event_pending);
    $display("test carry done");
  endtask
  task t_alarm;
    alarm_tod_value = {15'h0123, 5'h01, 6'h02, 6'h04};
    alarm_day_value = {15'h0009, 5'h01, 6'h02, 6'h04};
    alarm_tod_en = 1'b1;
    alarm_day_en = 1'b1;
    ld({15'h0008, 5'h01, 6'h02, 6'h03});
    rises(DIV);
    chk("tod only", 32'h11, event_pending);
    ld({15'h0009, 5'h01, 6'h02, 6'h03});
    rises(DIV);
    chk("both", 32'h31, event_pending);
    ld({15'h0009, 5'h01, 6'h02, 6'h04});
    chk("load match", 32'h00, event_pending);
    alarm_tod_en = 1'b0;
    alarm_day_en = 1'b0;
    ld({15'h0009, 5'h01, 6'h02, 6'h03});
    rises(DIV);
    chk("disabled", 32'h01, event_pending);
    $display("test alarm done");
  endtask
  task t_sw;
    clr;
    sw_load_value = 16'h0001;
    sw_load = 1'b1;
    cyc;
    sw_load = 1'b0;
    sw_en = 1'b1;
    rises(DIV);
    chk("sw one", 32'h0, sw_count);
    chk("sw no flag", 32'h01, event_pending);
    rises(DIV);
    chk("sw under", 32'hffff, sw_count);
    chk("sw flag", 32'h41, event_pending);
    sw_en = 1'b0;
    rises(DIV);
    chk("sw held", 32'hffff, sw_count);
    $display("test stopwatch done");
  endtask
  task t_irq;
    cyc;
    chk("masked", 32'h0, irq);
    event_en = 7'h40;
    regulator_wake_en = 1'b1;
    cyc;
    chk("wakes", 32'h7, {irq, sleep_wake, regulator_wake});
    regulator_wake_en = 1'b0;
    cyc;
    chk("reg gated", 32'h6, {irq, sleep_wake, regulator_wake});
    // Power logic restarts the system after the wake; rst_b stays high, state must hold
    repeat (4) cyc;
    chk("retained", 32'h41, event_pending);
    event_clear = 7'h40;
    cyc;
    event_clear = 7'h00;
    chk("cleared", 32'h01, event_pending);
    chk("irq drop", 32'h0, {irq, sleep_wake});
    $display("test irq done");
  endtask
  initial begin
    rst_b = 1'b0;
    crystal_clock_input = 1'b0;
    time_load = 1'b0;
    time_load_value = 32'h0;
    alarm_tod_en = 1'b0;
    alarm_day_en = 1'b0;
    alarm_tod_value = 32'h0;
    alarm_day_value = 32'h0;
    sw_en = 1'b0;
    sw_load = 1'b0;
    sw_load_value = 16'h0;
    event_en = 7'h00;
    event_clear = 7'h00;
    regulator_wake_en = 1'b0;
    repeat (20) @(posedge mclk);
    #1 rst_b = 1'b1;
    cyc;
    chk("reset", 32'h0, {event_pending, irq, regulator_wake, sw_count});
    t_tick;
    t_carry;
    t_alarm;
    t_sw;
    t_irq;
    wrap_up;
  end
  initial begin
    #20000;
    fails++;
    wrap_up;
  end
endmodule
bind wta_top wta_properties #(.SW_W(SW_W)) i_props (.mclk, .rst_b, .time_load,
  .time_load_value, .sw_load, .sw_load_value, .event_en, .event_clear, .regulator_wake_en,
  .cur_time, .sw_count, .event_pending, .irq, .sleep_wake, .regulator_wake);
